/* File: rtl/gscdl_pkg.sv */
// shared constants and carrier types of the column driver latch
package gscdl_pkg;
  localparam int unsigned PIX_W            = 6;
  localparam int unsigned HALF_W           = 3;
  localparam int unsigned SEL_W            = 8;
  localparam int unsigned NUM_COL          = 192;
  localparam int unsigned IDX_W            = 8;
  localparam int unsigned CNT_W            = 6;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 6'h01;
  // 64 strobes of three pixels make one line of 192
  localparam logic [CNT_W-1:0] CNT_LAST    = 6'h3f;
  localparam logic [IDX_W-1:0] PIX_PER_STB = 8'h03;
  localparam logic [IDX_W-1:0] IDX_TOP     = 8'hbf;
  localparam logic [IDX_W-1:0] OFS_TWO     = 8'h00;
  localparam logic [IDX_W-1:0] OFS_ONE     = 8'h01;
  localparam logic [IDX_W-1:0] OFS_ZERO    = 8'h02;
  localparam logic [SEL_W-1:0] SEL_BASE    = 8'h01;
  localparam logic [PIX_W-1:0] CODE_RESET  = 6'h00;
  localparam logic [SEL_W-1:0] SEL_RESET   = 8'h01;

  typedef struct packed {
    logic [PIX_W-1:0] two;
    logic [PIX_W-1:0] one;
    logic [PIX_W-1:0] zero;
  } gscdl_lanes_t;

  typedef struct packed {
    gscdl_lanes_t lanes;
    logic         pixel_strobe;
    logic         line_load_strobe;
    logic         phase_control;
    logic         direction_select;
    logic         chain_a;
    logic         chain_b;
  } gscdl_pins_t;

  // pixel strobe idles high, line load low, chain inputs high (not enabled)
  localparam gscdl_pins_t PINS_IDLE = '{lanes: '0, pixel_strobe: 1'b1,
    line_load_strobe: 1'b0, phase_control: 1'b0, direction_select: 1'b0,
    chain_a: 1'b1, chain_b: 1'b1};
endpackage

/* File: rtl/gscdl_column_latch.sv */
// pixel capture, line latch and level decode of the column driver
// Summary of operation
// - falling pixel strobe while enabled captures one 6-bit value per lane
// - first latch holds 192 six-bit entries, filled three per strobe in order
// - rising line-load strobe copies first latch into second latch driving outputs
// - direction low fills 1,2,3 upward; high fills 192,191,190 downward
// - direction select chooses which chain-enable pin is input and output
// - capture happens only while the chain-enable input is held low
// - after 192 pixels the chain-enable output goes low for the next driver
// - phase control high marks the high-current first phase of a line
// - upper and lower three bits of each held pixel decode separately
// - upper bits pick adjacent reference pair, lower bits one of eight steps
`timescale 1ns/100ps
`default_nettype none
module gscdl_column_latch import gscdl_pkg::*; (
  // clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // timing controller pins
  input  wire gscdl_lanes_t                        pixel_lanes,
  input  wire logic                                pixel_strobe,
  input  wire logic                                line_load_strobe,
  input  wire logic                                phase_control,
  input  wire logic                                direction_select,
  // chain-enable pins, oe low while driving
  input  wire logic                                chain_enable_a_in,
  output logic                                     chain_enable_a_out,
  output logic                                     chain_enable_a_oe_n,
  input  wire logic                                chain_enable_b_in,
  output logic                                     chain_enable_b_out,
  output logic                                     chain_enable_b_oe_n,
  // toward the level generator
  output logic [NUM_COL-1:0][PIX_W-1:0]            column_outputs,
  output logic [NUM_COL-1:0][SEL_W-1:0]            level_pair_sel,
  output logic [NUM_COL-1:0][SEL_W-1:0]            sub_level_sel,
  output logic                                     phase_high_current
);

  gscdl_pins_t            pins_raw;
  gscdl_pins_t            sync1_q;
  gscdl_pins_t            sync2_q;
  gscdl_pins_t            prev_q;
  logic                   pix_fall;
  logic                   load_rise;
  logic                   chain_in_n;
  logic                   capture;
  logic [CNT_W-1:0]       count_q;
  logic                   done_q;
  logic                   phase_q;
  logic [IDX_W-1:0]       idx_two;
  logic [IDX_W-1:0]       idx_one;
  logic [IDX_W-1:0]       idx_zero;
  logic [PIX_W-1:0]       latch1_q [NUM_COL];
  logic [NUM_COL-1:0][PIX_W-1:0] latch2_q;
  logic [NUM_COL-1:0][SEL_W-1:0] pair_q;
  logic [NUM_COL-1:0][SEL_W-1:0] sub_q;

  // entry index of a lane for the current strobe count
  function automatic logic [IDX_W-1:0] entry_idx(input logic dir,
                                                 input logic [CNT_W-1:0] cnt,
                                                 input logic [IDX_W-1:0] ofs);
    logic [IDX_W-1:0] base;
    base = IDX_W'(IDX_W'(cnt) * PIX_PER_STB) + ofs;
    return dir ? (IDX_TOP - base) : base;
  endfunction

  function automatic logic [SEL_W-1:0] one_hot(input logic [HALF_W-1:0] v);
    return SEL_BASE << v;
  endfunction

  assign pins_raw = '{lanes: pixel_lanes, pixel_strobe: pixel_strobe,
    line_load_strobe: line_load_strobe, phase_control: phase_control,
    direction_select: direction_select, chain_a: chain_enable_a_in,
    chain_b: chain_enable_b_in};

  // two-stage synchroniser, then one stage for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
      prev_q  <= PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign pix_fall   = prev_q.pixel_strobe & ~sync2_q.pixel_strobe;
  assign load_rise  = ~prev_q.line_load_strobe & sync2_q.line_load_strobe;
  assign chain_in_n = sync2_q.direction_select ? sync2_q.chain_b : sync2_q.chain_a;
  assign capture    = pix_fall & ~chain_in_n & ~done_q;

  assign idx_two  = entry_idx(sync2_q.direction_select, count_q, OFS_TWO);
  assign idx_one  = entry_idx(sync2_q.direction_select, count_q, OFS_ONE);
  assign idx_zero = entry_idx(sync2_q.direction_select, count_q, OFS_ZERO);

  // latch address selector; line load outranks a same-cycle strobe
  always_ff @(posedge core_clk) begin
    if (rst || load_rise) begin
      count_q <= CNT_ZERO;
      done_q  <= 1'b0;
    end else if (capture) begin
      count_q <= count_q + CNT_ONE;
      if (count_q == CNT_LAST) begin
        done_q <= 1'b1;
      end
    end
  end

  // first latch, three entries per strobe
  always_ff @(posedge core_clk) begin
    if (capture) begin
      latch1_q[idx_two]  <= sync2_q.lanes.two;
      latch1_q[idx_one]  <= sync2_q.lanes.one;
      latch1_q[idx_zero] <= sync2_q.lanes.zero;
    end
  end

  // second latch and per-pixel decode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_COL; i++) begin
        latch2_q[i] <= CODE_RESET;
        pair_q[i]   <= SEL_RESET;
        sub_q[i]    <= SEL_RESET;
      end
    end else if (load_rise) begin
      for (int i = 0; i < NUM_COL; i++) begin
        latch2_q[i] <= latch1_q[i];
        pair_q[i]   <= one_hot(latch1_q[i][PIX_W-1:HALF_W]);
        sub_q[i]    <= one_hot(latch1_q[i][HALF_W-1:0]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= sync2_q.phase_control;
    end
  end

  assign column_outputs      = latch2_q;
  assign level_pair_sel      = pair_q;
  assign sub_level_sel       = sub_q;
  assign phase_high_current  = phase_q;
  assign chain_enable_a_out  = ~done_q;
  assign chain_enable_b_out  = ~done_q;
  assign chain_enable_a_oe_n = ~sync2_q.direction_select;
  assign chain_enable_b_oe_n = sync2_q.direction_select;

  // checks
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic chain_out_n;
  assign chain_out_n = sync2_q.direction_select ? chain_enable_a_out : chain_enable_b_out;

  // capture that is not lost to a same-cycle line load
  sequence plain_capture_s;
    capture && !load_rise;
  endsequence

  sequence last_strobe_s;
    capture && !load_rise && (count_q == CNT_LAST);
  endsequence

  sequence mid_strobe_s;
    capture && !load_rise && (count_q != CNT_LAST);
  endsequence

  sequence line_start_s;
    load_rise;
  endsequence

  // strobe and line load in one cycle: the load wins
  sequence clash_s;
    capture && load_rise;
  endsequence

  chk_capture_count: assert property (plain_capture_s |=>
      count_q == $past(count_q) + CNT_ONE)
    else $error("strobe count did not advance on capture");
  chk_lane_store: assert property (plain_capture_s |=>
      latch1_q[$past(idx_two)] == $past(sync2_q.lanes.two) &&
      latch1_q[$past(idx_zero)] == $past(sync2_q.lanes.zero))
    else $error("lane data not stored at its entry");
  chk_lane_mid: assert property (plain_capture_s |=>
      latch1_q[$past(idx_one)] == $past(sync2_q.lanes.one))
    else $error("middle lane not stored at its entry");
  chk_fill_order: assert property (capture && count_q == CNT_ZERO |->
      (sync2_q.direction_select ?
        (idx_two == IDX_TOP && idx_zero == IDX_TOP - OFS_ZERO) :
        (idx_two == OFS_TWO && idx_zero == OFS_ZERO)))
    else $error("first strobe aimed at wrong entries");
  chk_pin_roles: assert property (
      chain_enable_a_oe_n == !sync2_q.direction_select &&
      chain_enable_b_oe_n != chain_enable_a_oe_n)
    else $error("chain pin roles wrong for direction");
  chk_enable_gate: assert property (chain_in_n && !load_rise |=>
      count_q == $past(count_q))
    else $error("capture while chain input inactive");
  chk_chain_done: assert property (last_strobe_s ##1 !load_rise |-> !chain_out_n)
    else $error("chain output not low after full line");
  chk_full_set: assert property (last_strobe_s |=> done_q)
    else $error("line not marked full after last strobe");
  chk_early_full: assert property (mid_strobe_s |=> !done_q && chain_out_n)
    else $error("chain output low before line was full");
  chk_full_hold: assert property (done_q && !load_rise |=> done_q && $stable(count_q))
    else $error("strobe accepted after line was full");
  chk_count_idle: assert property (!capture && !load_rise |=>
      $stable(count_q) && $stable(done_q))
    else $error("strobe count moved without a capture");
  chk_line_release: assert property (line_start_s |=>
      chain_out_n && count_q == CNT_ZERO)
    else $error("line load did not re-arm the fill");
  chk_load_wins: assert property (clash_s |=> count_q == CNT_ZERO && !done_q)
    else $error("strobe in line-load cycle was not dropped");
  chk_copy_line: assert property (line_start_s |=>
      column_outputs[0] == $past(latch1_q[0]) &&
      column_outputs[NUM_COL-1] == $past(latch1_q[NUM_COL-1]))
    else $error("second latch did not take first latch");
  chk_out_stand: assert property (!load_rise |=> $stable(column_outputs))
    else $error("outputs changed without a line load");
  chk_decode_sel: assert property (line_start_s |=>
      level_pair_sel[0] == (SEL_BASE << column_outputs[0][PIX_W-1:HALF_W]) &&
      sub_level_sel[0] == (SEL_BASE << column_outputs[0][HALF_W-1:0]))
    else $error("decode does not match held code");
  chk_decode_tail: assert property (line_start_s |=>
      level_pair_sel[NUM_COL-1] == (SEL_BASE << column_outputs[NUM_COL-1][PIX_W-1:HALF_W]) &&
      sub_level_sel[NUM_COL-1] == (SEL_BASE << column_outputs[NUM_COL-1][HALF_W-1:0]))
    else $error("decode of last column does not match held code");
  chk_sel_onehot: assert property (
      $onehot(level_pair_sel[0]) && $onehot(sub_level_sel[0]) &&
      $onehot(level_pair_sel[NUM_COL-1]) && $onehot(sub_level_sel[NUM_COL-1]))
    else $error("level select not one-hot");
  chk_phase_follow: assert property ($rose(sync2_q.phase_control) |=>
      phase_high_current ##1 (phase_high_current == $past(sync2_q.phase_control)))
    else $error("phase output does not track phase control");
  chk_phase_drop: assert property ($fell(sync2_q.phase_control) |=> !phase_high_current)
    else $error("phase output stayed high after phase control fell");

endmodule // gscdl_column_latch
`default_nettype wire

/* File: test/gscdl_ctrl_model.sv */
// timing controller model driving strobes and pixel lanes
`timescale 1ns/100ps
`default_nettype none
module gscdl_ctrl_model import gscdl_pkg::*; (
  // clock
  input  wire logic         core_clk,
  // controller pins
  output var gscdl_lanes_t  pixel_lanes,
  output var logic          pixel_strobe,
  output var logic          line_load_strobe
);
  initial begin
    pixel_lanes = '0;
    pixel_strobe = 1'b1;
    line_load_strobe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // three pixels on 18 inputs, strobe slowed like a halved dot clock
  task automatic send(input gscdl_lanes_t d);
    pixel_lanes = d; // all three lanes, 18 bits at once
    tick(3);
    pixel_strobe = 1'b0;
    tick(4);
    pixel_strobe = 1'b1;
    // lanes released once the strobe is back high: show the inverse
    pixel_lanes = ~d;
    tick(4);
  endtask
  task automatic load();
    line_load_strobe = 1'b1;
    tick(4);
    line_load_strobe = 1'b0;
    tick(6);
  endtask
endmodule // gscdl_ctrl_model
`default_nettype wire

/* File: test/gscdl_column_latch_bench.sv */
// self-checking bench of the column driver latch
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: value mismatch", $time); end end
module gscdl_column_latch_bench import gscdl_pkg::*;;
  logic                          core_clk;
  logic                          rst;
  logic                          phase_control;
  logic                          direction_select;
  logic                          up_n;
  logic                          a_out, a_oe_n, b_out, b_oe_n, phase_high_current;
  logic                          pixel_strobe, line_load_strobe;
  gscdl_lanes_t                  pixel_lanes;
  logic [NUM_COL-1:0][PIX_W-1:0] column_outputs;
  logic [NUM_COL-1:0][SEL_W-1:0] level_pair_sel, sub_level_sel;
  logic [PIX_W-1:0]              exp_code [NUM_COL];
  logic [7:0]                    lfsr_q;
  int                            n_mismatch = 0;
  int                            samples_checked = 0;
  // chain pins: design drives when oe_n low, else upstream level
  wire                           a_pin = a_oe_n ? up_n : a_out;
  wire                           b_pin = b_oe_n ? up_n : b_out;
  gscdl_ctrl_model ctrl_u (.core_clk(core_clk), .pixel_lanes(pixel_lanes),
    .pixel_strobe(pixel_strobe), .line_load_strobe(line_load_strobe));
  gscdl_column_latch dut_u (.core_clk(core_clk), .rst(rst), .pixel_lanes(pixel_lanes),
    .pixel_strobe(pixel_strobe), .line_load_strobe(line_load_strobe),
    .phase_control(phase_control), .direction_select(direction_select),
    .chain_enable_a_in(a_pin), .chain_enable_a_out(a_out), .chain_enable_a_oe_n(a_oe_n),
    .chain_enable_b_in(b_pin), .chain_enable_b_out(b_out), .chain_enable_b_oe_n(b_oe_n),
    .column_outputs(column_outputs), .level_pair_sel(level_pair_sel),
    .sub_level_sel(sub_level_sel), .phase_high_current(phase_high_current));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int col_of(input logic dir, input int k, input int lane);
    return dir ? int'(NUM_COL) - 1 - 3 * k - lane : 3 * k + lane;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_chain(input logic lvl);
    int i;
    for (i = 0; i < 20 && (direction_select ? a_out : b_out) !== lvl; i++) begin
      @(posedge core_clk);
    end
    if (i == 20) begin
      n_mismatch++;
      $display("ERROR %0t: chain wait timeout", $time);
      close_out();
    end
  endtask
  task automatic run_line(input logic dir);
    gscdl_lanes_t d;
    direction_select = dir;
    up_n = 1'b1;
    ctrl_u.tick(6);
    `CHK(a_oe_n, ~dir)
    `CHK(b_oe_n, dir)
    // strobe while not enabled must be dropped
    ctrl_u.send(18'h15555);
    up_n = 1'b0;
    for (int k = 0; k < 64; k++) begin
      repeat (3) begin
        lfsr_q = lfsr_next(lfsr_q);
        d = {d[11:0], lfsr_q[5:0]};
      end
      if (k == 0) d = '0;
      if (k == 63) d = '1;
      exp_code[col_of(dir, k, 0)] = d.two;
      exp_code[col_of(dir, k, 1)] = d.one;
      exp_code[col_of(dir, k, 2)] = d.zero;
      ctrl_u.send(d);
    end
    wait_chain(1'b0);
    `CHK(dir ? a_out : b_out, 1'b0)
    // extra strobe on a full line must be ignored; differs from the first entries
    ctrl_u.send(18'h2aaaa);
    ctrl_u.load();
    wait_chain(1'b1);
    `CHK(dir ? a_out : b_out, 1'b1)
    for (int i = 0; i < int'(NUM_COL); i++) begin
      `CHK(column_outputs[i], exp_code[i])
      `CHK(level_pair_sel[i], SEL_BASE << exp_code[i][5:3])
      `CHK(sub_level_sel[i], SEL_BASE << exp_code[i][2:0])
    end
    $display("test line direction %0d done", dir);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    $display("ERROR %0t: run timeout", $time);
    close_out();
  end
  initial begin
    rst = 1'b1;
    phase_control = 1'b0;
    direction_select = 1'b0;
    up_n = 1'b1;
    lfsr_q = 8'h5f;
    repeat (4) @(posedge core_clk);
    #2;
    rst = 1'b0;
    `CHK(b_out, 1'b1)
    `CHK(column_outputs[0], CODE_RESET)
    run_line(1'b0);
    run_line(1'b1);
    phase_control = 1'b1;
    ctrl_u.tick(5);
    `CHK(phase_high_current, 1'b1)
    phase_control = 1'b0;
    ctrl_u.tick(5);
    `CHK(phase_high_current, 1'b0)
    $display("test phase control done");
    close_out();
  end
endmodule // gscdl_column_latch_bench
`default_nettype wire
